// file: hdl/lcm_pkg.sv
// Constants and types shared by the logic cell design
// How it works
// RULE1: cell runs in one of three modes
// RULE2: seven inputs: four data, feedback, carry, cascade
// RULE3: register controls come from cluster-wide signals
// RULE4: normal table uses a, b, d and c-or-carry
// RULE5: normal table output may join cascade chain
// RULE6: packed register unless carry feeds the table
// RULE7: arithmetic uses sum table and carry table
// RULE8: cascade chain usable together with carry chain
// RULE9: arithmetic drives registered and unregistered result
// RULE10: counter enable and direction from a, b; the second cell (CFG_SECOND) ties both high
// RULE11: count table, carry table, load mux, clear AND
// RULE12: sync clear and load act cluster-wide
// RULE13: sync clear or load overrides cascade input
// RULE14: sync clear wins over sync load
// RULE15: two cluster clock enables, selectable per cell
// RULE16: first cell has register feedback selector
// RULE17: native async clear; preset and load emulated
// RULE18: optional chip-wide reset overrides all controls
// RULE19: preset registers go preset on chip reset
// RULE20: preset-load registers unknown after chip reset
// RULE21: cascade joins by AND, or OR by inversion
// RULE22: register acts as D, T, JK, SR or bypass
// RULE23: disabled clock enable holds and ignores sync
`default_nettype none
package lcm_pkg;
   typedef enum logic [1:0] {
      LCM_NORMAL,
      LCM_ARITH,
      LCM_COUNTER,
      LCM_MODE_SPARE
   } lcm_mode_e;
   typedef enum logic [2:0] {
      LCM_REG_D,
      LCM_REG_T,
      LCM_REG_JK,
      LCM_REG_SR,
      LCM_REG_BYPASS
   } lcm_reg_e;
   // Register offsets
   localparam logic [3:0]  ADDR_CFG   = 4'h0;
   localparam logic [3:0]  ADDR_MASK  = 4'h4;
   localparam logic [3:0]  ADDR_STAT  = 4'h8;
   // Configuration field positions
   localparam int          CFG_MODE_LO  = 0;
   localparam int          CFG_CSEL     = 2;
   localparam int          CFG_CAS_EN   = 3;
   localparam int          CFG_CAS_OR   = 4;
   localparam int          CFG_PACK     = 5;
   localparam int          CFG_CE_SEL   = 6;
   localparam int          CFG_REG_LO   = 7;
   localparam int          CFG_FB_SEL   = 10;
   localparam int          CFG_PRESET   = 11;
   localparam int          CFG_PLOAD    = 12;
   localparam int          CFG_CHIP_EN  = 13;
   localparam int          CFG_FIRST    = 14;
   localparam int          CFG_SECOND   = 15;
   // Status field positions
   localparam int          ST_Q        = 0;
   localparam int          ST_UNKNOWN  = 1;
   localparam int          ST_COMB     = 2;
   localparam int          ST_CARRY    = 3;
   localparam int          ST_CASCADE  = 4;
   // Reset values
   localparam logic [15:0] CFG_RST    = 16'h0000;
   localparam logic [15:0] MASK_RST   = 16'h0000;
   // Fixed counter tables, index {x2, x1, x0}
   localparam logic [7:0]  CNT_DATA   = 8'h6a;
   localparam logic [7:0]  CNT_CARRY  = 8'h84;
endpackage : lcm_pkg
`default_nettype wire

// file: hdl/lcm_lut.sv
// Look-up table of four inputs selecting one bit of a 16-bit mask
`default_nettype none
module lcm_lut (
   // Table contents and select
   input  wire logic [15:0] mask,
   input  wire logic [3:0]  sel,
   // Result
   output logic             y
);
   assign y = mask[sel];
endmodule : lcm_lut
`default_nettype wire

// file: hdl/lcm_cascade.sv
// Cascade stage joining a partial result with the chain
`default_nettype none
module lcm_cascade (
   // Chain inputs
   input  wire logic part_in,
   input  wire logic chain_in,
   input  wire logic enable,
   input  wire logic or_mode,
   // Chain output
   output logic      chain_out
);
   // OR is built from AND by inverting inputs and output
   always_comb begin
      if (!enable) begin
         chain_out = part_in;
      end else if (or_mode) begin
         chain_out = ~(~part_in & ~chain_in); // RULE21
      end else begin
         chain_out = part_in & chain_in; // RULE21
      end
   end
endmodule : lcm_cascade
`default_nettype wire

// file: hdl/lcm_cell.sv
// Logic cell: table, carry, cascade and programmable register
`default_nettype none
module lcm_cell (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Cluster routing data
   input  wire logic        data_in_a,
   input  wire logic        data_in_b,
   input  wire logic        data_in_c,
   input  wire logic        data_in_d,
   // Chains from the preceding cell
   input  wire logic        carry_in,
   input  wire logic        cascade_in, // RULE2
   // Cluster-wide register controls
   input  wire logic        clk_ena1,
   input  wire logic        clk_ena2,
   input  wire logic        async_clr,
   input  wire logic        async_load,
   input  wire logic        sync_clr,
   input  wire logic        sync_load,
   input  wire logic        chip_wide_reset_n,
   // Cell outputs
   output logic             comb_out,
   output logic             reg_out,
   output logic             carry_out,
   output logic             cascade_out
);
   // ***************************************************
   // Configuration registers
   // ***************************************************
   logic [15:0]        cfg_q;
   logic [15:0]        mask_q;
   logic [15:0]        rdata_q;
   lcm_pkg::lcm_mode_e mode;
   lcm_pkg::lcm_reg_e  rtype;
   logic               csel;
   logic               cas_en;
   logic               cas_or;
   logic               pack_en;
   logic               ce_sel;
   logic               fb_sel;
   logic               preset_em;
   logic               pload_em;
   logic               chip_en;
   logic               is_first;
   logic               is_second;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_q  <= lcm_pkg::CFG_RST;
         mask_q <= lcm_pkg::MASK_RST;
      end else if (wr) begin
         if (addr == lcm_pkg::ADDR_CFG) begin
            cfg_q <= wdata;
         end
         if (addr == lcm_pkg::ADDR_MASK) begin
            mask_q <= wdata;
         end
      end
   end

   assign mode      = lcm_pkg::lcm_mode_e'(
                      cfg_q[lcm_pkg::CFG_MODE_LO +: 2]); // RULE1
   assign rtype     = lcm_pkg::lcm_reg_e'(
                      cfg_q[lcm_pkg::CFG_REG_LO +: 3]);
   assign csel      = cfg_q[lcm_pkg::CFG_CSEL];
   assign cas_en    = cfg_q[lcm_pkg::CFG_CAS_EN];
   assign cas_or    = cfg_q[lcm_pkg::CFG_CAS_OR];
   assign pack_en   = cfg_q[lcm_pkg::CFG_PACK];
   assign ce_sel    = cfg_q[lcm_pkg::CFG_CE_SEL];
   assign fb_sel    = cfg_q[lcm_pkg::CFG_FB_SEL];
   assign preset_em = cfg_q[lcm_pkg::CFG_PRESET];
   assign pload_em  = cfg_q[lcm_pkg::CFG_PLOAD];
   assign chip_en   = cfg_q[lcm_pkg::CFG_CHIP_EN];
   assign is_first  = cfg_q[lcm_pkg::CFG_FIRST];
   assign is_second = cfg_q[lcm_pkg::CFG_SECOND];

   // ***************************************************
   // Table input routing per mode
   // ***************************************************
   logic        s_q;
   logic        unk_q;
   logic        q;
   logic        fb_c;
   logic        cnt_en;
   logic        cnt_up;
   logic [15:0] mask_main;
   logic [15:0] mask_cy;
   logic [3:0]  sel_main;
   logic [3:0]  sel_cy;
   logic        y_main;
   logic        y_cy;

   // Stored bit is inverted for emulated preset
   assign q = s_q ^ preset_em; // RULE17

   // First cell may take its own register as input c
   assign fb_c = (is_first && fb_sel) ? q : data_in_c; // RULE16

   // Second cell has no a/b control path
   assign cnt_en = is_second ? 1'b1 : data_in_a; // RULE10
   assign cnt_up = is_second ? 1'b1 : data_in_b; // RULE10

   always_comb begin
      mask_main = mask_q;
      mask_cy   = {8'h00, mask_q[15:8]};
      sel_main  = 4'h0;
      sel_cy    = 4'h0;
      case (mode)
         lcm_pkg::LCM_NORMAL: begin
            sel_main = {csel ? carry_in : fb_c, data_in_d,
                        data_in_b, data_in_a}; // RULE4
         end
         lcm_pkg::LCM_ARITH: begin
            sel_main = {1'b0, carry_in, data_in_b,
                        data_in_a}; // RULE7
            sel_cy   = {1'b0, carry_in, data_in_b,
                        data_in_a}; // RULE7
         end
         lcm_pkg::LCM_COUNTER: begin
            mask_main = {8'h00, lcm_pkg::CNT_DATA}; // RULE11
            mask_cy   = {8'h00, lcm_pkg::CNT_CARRY}; // RULE11
            sel_main  = {1'b0, cnt_en, carry_in, q};
            sel_cy    = {1'b0, cnt_up, carry_in, q};
         end
         default: begin
            sel_main = 4'h0;
         end
      endcase
   end

   lcm_lut u_lut_main (
      .mask (mask_main),
      .sel  (sel_main),
      .y    (y_main)
   );

   lcm_lut u_lut_carry (
      .mask (mask_cy),
      .sel  (sel_cy),
      .y    (y_cy)
   );

   // ***************************************************
   // Carry and cascade chains
   // ***************************************************
   logic cas_res;
   logic carry_used;

   // Carry chain runs beside cascade in arithmetic and counter modes; normal mode ties carry_out low
   assign carry_out = (mode == lcm_pkg::LCM_NORMAL) ?
                      1'b0 : y_cy; // RULE7 RULE8

   lcm_cascade u_cascade (
      .part_in   (y_main),
      .chain_in  (cascade_in),
      .enable    (cas_en),
      .or_mode   (cas_or),
      .chain_out (cas_res)
   );

   assign cascade_out = cas_res; // RULE5 RULE8

   // Packing is lost when carry occupies the c input
   assign carry_used = (mode == lcm_pkg::LCM_NORMAL) && csel;

   // ***************************************************
   // Register data path
   // ***************************************************
   logic ce;
   logic pack;
   logic d_src;
   logic jk_k;
   logic d_fn;
   logic d_sync;

   assign ce = ce_sel ? clk_ena2 : clk_ena1; // RULE15

   assign pack = pack_en && !carry_used &&
                 (mode == lcm_pkg::LCM_NORMAL); // RULE6

   // Packed register takes an unrelated input
   assign d_src = pack ? data_in_d : cas_res; // RULE6
   assign jk_k  = data_in_c;

   always_comb begin
      case (rtype)
         lcm_pkg::LCM_REG_D: begin
            d_fn = d_src; // RULE22
         end
         lcm_pkg::LCM_REG_T: begin
            d_fn = q ^ d_src; // RULE22
         end
         lcm_pkg::LCM_REG_JK: begin
            d_fn = (d_src & ~q) | (~jk_k & q); // RULE22
         end
         lcm_pkg::LCM_REG_SR: begin
            d_fn = d_src | (~jk_k & q); // RULE22
         end
         default: begin
            d_fn = q;
         end
      endcase
      if (mode == lcm_pkg::LCM_COUNTER) begin
         d_fn = cas_res;
      end
   end

   // Load mux then clear AND, both over the register function value d_fn
   assign d_sync = (sync_load ? data_in_c : d_fn) &
                   ~sync_clr; // RULE11 RULE12 RULE13 RULE14

   // ***************************************************
   // Programmable register
   // ***************************************************
   logic chip_rst;
   logic aload_act;

   assign chip_rst  = chip_en && !chip_wide_reset_n;
   assign aload_act = pload_em && async_load;

   // Controls are shared by the whole cluster
   always_ff @(posedge clk_sys) begin // RULE3
      if (!rstn) begin
         s_q <= 1'b0;
      end else if (chip_rst) begin
         s_q <= 1'b0; // RULE18 RULE19
      end else if (async_clr) begin
         s_q <= 1'b0; // RULE17
      end else if (aload_act) begin
         s_q <= data_in_c ^ preset_em; // RULE17
      end else if (ce) begin
         s_q <= d_sync ^ preset_em; // RULE23
      end
   end

   // Emulated preset-load state is not trusted until written
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         unk_q <= 1'b1;
      end else if (chip_rst) begin
         unk_q <= pload_em; // RULE20
      end else if (!pload_em) begin
         unk_q <= 1'b0;
      end else if (aload_act || ce || async_clr) begin
         unk_q <= 1'b0; // RULE20
      end
   end

   // Output stage
   assign comb_out = cas_res; // RULE9
   assign reg_out  = (rtype == lcm_pkg::LCM_REG_BYPASS) ?
                     cas_res : q; // RULE9 RULE22

   // ***************************************************
   // Register read port
   // ***************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         case (addr)
            lcm_pkg::ADDR_CFG: begin
               rdata_q <= cfg_q;
            end
            lcm_pkg::ADDR_MASK: begin
               rdata_q <= mask_q;
            end
            lcm_pkg::ADDR_STAT: begin
               rdata_q <= {11'h000, cas_res, carry_out,
                           comb_out, unk_q, q};
            end
            default: begin
               rdata_q <= 16'h0000;
            end
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign rdata = rdata_q;

   // ***************************************************
   // Assertions
   // ***************************************************
   logic no_async;
   assign no_async = !chip_rst && !async_clr && !aload_act;

   AST_CHIP_RST: assert property (@(posedge clk_sys) // RULE18
      disable iff (!rstn) chip_rst |=> (s_q == 1'b0))
      else $error("chip reset did not clear register");

   AST_PRESET_RST: assert property (@(posedge clk_sys) // RULE19
      disable iff (!rstn)
      (chip_rst && preset_em && $stable(cfg_q)) ##1
      $stable(cfg_q) |-> reg_out || rtype ==
      lcm_pkg::LCM_REG_BYPASS)
      else $error("preset register not preset by chip reset");

   AST_CLR_WINS: assert property (@(posedge clk_sys) // RULE14
      disable iff (!rstn)
      (no_async && ce && sync_clr && sync_load) |=>
      (s_q == $past(preset_em)))
      else $error("sync load beat sync clear");

   AST_HOLD: assert property (@(posedge clk_sys) // RULE23
      disable iff (!rstn)
      (no_async && !ce) |=> $stable(s_q))
      else $error("register changed while disabled");

   AST_LOAD: assert property (@(posedge clk_sys) // RULE13
      disable iff (!rstn)
      (no_async && ce && sync_load && !sync_clr) |=>
      (s_q == ($past(data_in_c) ^ $past(preset_em))))
      else $error("sync load value wrong");

   AST_ACLR: assert property (@(posedge clk_sys) // RULE17
      disable iff (!rstn)
      (!chip_rst && async_clr) |=> !s_q)
      else $error("async clear missed");

   AST_UNKNOWN: assert property (@(posedge clk_sys) // RULE20
      disable iff (!rstn)
      (chip_rst && pload_em) |=> unk_q)
      else $error("unknown flag not raised");

   AST_CNT_CARRY: assert property (@(posedge clk_sys) // RULE11
      disable iff (!rstn) (mode == lcm_pkg::LCM_COUNTER) |->
      carry_out == (carry_in & (cnt_up ? q : ~q)))
      else $error("counter carry wrong");

   AST_PACK: assert property (@(posedge clk_sys) // RULE6
      disable iff (!rstn)
      (no_async && ce && carry_used && pack_en && !sync_clr &&
      !sync_load && rtype == lcm_pkg::LCM_REG_D) |=>
      (s_q == ($past(cas_res) ^ $past(preset_em))))
      else $error("packing used with carry input");

   COV_COUNT: cover property (@(posedge clk_sys)
      disable iff (!rstn)
      mode == lcm_pkg::LCM_COUNTER && ce && cnt_en ##1
      ce && cnt_en);
   COV_ARITH: cover property (@(posedge clk_sys)
      disable iff (!rstn)
      mode == lcm_pkg::LCM_ARITH && carry_out && cas_en);
   COV_CHIP: cover property (@(posedge clk_sys)
      disable iff (!rstn) chip_rst && preset_em);
endmodule : lcm_cell
`default_nettype wire

// file: test/lcm_nbr.sv
// Model of the preceding cell that feeds the carry and cascade chains
`default_nettype none
module lcm_nbr (
   // Preceding cell results
   input  wire logic part,
   input  wire logic gen,
   // Chains into the cell
   output logic      carry_in,
   output logic      cascade_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Chain outputs of a neighbour follow its logic at once
   assign carry_in   = gen;
   assign cascade_in = part;
endmodule : lcm_nbr
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the logic cell
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0;
   logic [3:0]  addr    = 4'h0;
   logic [15:0] wdata   = 16'h0000;
   logic [15:0] rdata, v;
   logic        a = 1'h0, b = 1'h0, c = 1'h0, d = 1'h0;
   logic        clk_ena1 = 1'h0, clk_ena2 = 1'h0, async_clr = 1'h0;
   logic        async_load = 1'h0, sync_clr = 1'h0, sync_load = 1'h0;
   logic        chip_n = 1'h1, nb_part = 1'h0, nb_gen = 1'h0, eq;
   logic        carry_in, cascade_in, comb_out, reg_out;
   logic        carry_out, cascade_out;
   int          fail_count = 0, n_compared = 0;
   always #4 clk_sys = ~clk_sys;
   lcm_nbr nbr (.part(nb_part), .gen(nb_gen), .carry_in(carry_in),
      .cascade_in(cascade_in));
   lcm_cell dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .data_in_a(a),
      .data_in_b(b), .data_in_c(c), .data_in_d(d), .carry_in(carry_in),
      .cascade_in(cascade_in), .clk_ena1(clk_ena1), .clk_ena2(clk_ena2),
      .async_clr(async_clr), .async_load(async_load),
      .sync_clr(sync_clr), .sync_load(sync_load),
      .chip_wide_reset_n(chip_n), .comb_out(comb_out),
      .reg_out(reg_out), .carry_out(carry_out),
      .cascade_out(cascade_out));
   // ****************************************
   // Register port tasks
   // ****************************************
   task wr_reg(input logic [3:0] ad, input logic [15:0] dt);
      @(posedge clk_sys);
      addr <= ad;
      wdata <= dt;
      wr <= 1'h1;
      @(posedge clk_sys);
      wr <= 1'h0;
      #1;
   endtask : wr_reg
   task rd_reg(input logic [3:0] ad, output logic [15:0] dt);
      @(posedge clk_sys);
      addr <= ad;
      rd <= 1'h1;
      @(posedge clk_sys);
      rd <= 1'h0;
      #1;
      dt = rdata;
   endtask : rd_reg
   task edge1;
      @(posedge clk_sys);
      #1;
   endtask : edge1
   task results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (3000) @(posedge clk_sys);
      fail_count++;
      results();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'h1;
      rd_reg(4'h0, v); `CHK("cfg", 16'h0000, v)
      rd_reg(4'h8, v); `CHK("stat", 16'h0000, v)
      wr_reg(4'h4, 16'h1234);
      wr_reg(4'hc, 16'hffff);
      rd_reg(4'hc, v); `CHK("unmapped", 16'h0000, v)
      rd_reg(4'h4, v); `CHK("mask", 16'h1234, v)
      $display("test registers done");
      wr_reg(4'h4, 16'h8000);
      @(posedge clk_sys);
      {a, b, c, d} <= 4'hf;
      #1; `CHK("comb", 1'h1, comb_out)
      @(posedge clk_sys);
      c <= 1'h0;
      #1; `CHK("comb", 1'h0, comb_out)
      wr_reg(4'h0, 16'h0004);
      @(posedge clk_sys);
      nb_gen <= 1'h1;
      #1; `CHK("comb", 1'h1, comb_out)
      wr_reg(4'h0, 16'h000c);
      `CHK("comb", 1'h0, comb_out)
      `CHK("cascade", 1'h0, cascade_out)
      wr_reg(4'h0, 16'h001c);
      `CHK("comb", 1'h1, comb_out)
      wr_reg(4'h4, 16'h0000);
      @(posedge clk_sys);
      nb_part <= 1'h1;
      #1; `CHK("cascade", 1'h1, cascade_out)
      wr_reg(4'h0, 16'h0020);
      @(posedge clk_sys);
      clk_ena1 <= 1'h1;
      edge1();
      `CHK("reg", 1'h1, reg_out)
      `CHK("comb", 1'h0, comb_out)
      wr_reg(4'h0, 16'h0024);
      edge1(); `CHK("reg", 1'h0, reg_out)
      $display("test normal done");
      wr_reg(4'h4, 16'he896);
      wr_reg(4'h0, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         {nb_gen, b, a} <= i[2:0];
         #1; `CHK("sum", ^i[2:0], comb_out)
         `CHK("carry", (i[0] & i[1]) | (i[2] & (i[0] | i[1])),
            carry_out)
         edge1(); `CHK("reg", ^i[2:0], reg_out)
         `CHK("sum", ^i[2:0], comb_out)
      end
      @(posedge clk_sys);
      nb_part <= 1'h0;
      {nb_gen, b, a} <= 3'h1;
      wr_reg(4'h0, 16'h0009);
      `CHK("sum", 1'h0, comb_out)
      `CHK("carry", 1'h0, carry_out)
      $display("test arith done");
      wr_reg(4'h0, 16'h0002);
      @(posedge clk_sys);
      {nb_gen, b, a} <= 3'h7;
      sync_clr <= 1'h1;
      @(posedge clk_sys);
      sync_clr <= 1'h0;
      #1; `CHK("reg", 1'h0, reg_out)
      eq = 1'h0;
      for (int k = 0; k < 3; k++) begin
         edge1();
         eq = ~eq;
         `CHK("count", eq, reg_out)
         `CHK("carry", eq, carry_out)
      end
      @(posedge clk_sys);
      b <= 1'h0;
      eq = ~eq;
      #1; `CHK("count", eq, reg_out)
      `CHK("carry", ~eq, carry_out)
      @(posedge clk_sys);
      a <= 1'h0;
      eq = ~eq;
      edge1(); `CHK("hold", eq, reg_out)
      @(posedge clk_sys);
      c <= 1'h0;
      sync_load <= 1'h1;
      @(posedge clk_sys);
      sync_load <= 1'h0;
      #1; `CHK("load", 1'h0, reg_out)
      @(posedge clk_sys);
      {sync_clr, sync_load} <= 2'h3;
      c <= 1'h1;
      @(posedge clk_sys);
      {sync_clr, sync_load} <= 2'h0;
      #1; `CHK("clr", 1'h0, reg_out)
      wr_reg(4'h0, 16'h000a);
      @(posedge clk_sys);
      sync_load <= 1'h1;
      @(posedge clk_sys);
      sync_load <= 1'h0;
      clk_ena1 <= 1'h0;
      #1; `CHK("load", 1'h1, reg_out)
      @(posedge clk_sys);
      sync_clr <= 1'h1;
      @(posedge clk_sys);
      sync_clr <= 1'h0;
      #1; `CHK("held", 1'h1, reg_out)
      wr_reg(4'h0, 16'h0042);
      @(posedge clk_sys);
      {a, b, clk_ena2} <= 3'h7;
      @(posedge clk_sys);
      clk_ena2 <= 1'h0;
      #1; `CHK("count", 1'h0, reg_out)
      wr_reg(4'h0, 16'h8002);
      @(posedge clk_sys);
      {a, b, clk_ena1} <= 3'h1;
      edge1(); `CHK("count", 1'h1, reg_out)
      `CHK("carry", 1'h1, carry_out)
      $display("test counter done");
      wr_reg(4'h4, 16'hffff);
      wr_reg(4'h0, 16'h0000);
      edge1(); `CHK("reg", 1'h1, reg_out)
      @(posedge clk_sys);
      async_clr <= 1'h1;
      @(posedge clk_sys);
      async_clr <= 1'h0;
      #1; `CHK("aclr", 1'h0, reg_out)
      wr_reg(4'h0, 16'h2000);
      @(posedge clk_sys);
      chip_n <= 1'h0;
      @(posedge clk_sys);
      chip_n <= 1'h1;
      clk_ena1 <= 1'h0;
      #1; `CHK("chip", 1'h0, reg_out)
      wr_reg(4'h0, 16'h2800);
      @(posedge clk_sys);
      chip_n <= 1'h0;
      @(posedge clk_sys);
      chip_n <= 1'h1;
      #1; `CHK("preset", 1'h1, reg_out)
      wr_reg(4'h0, 16'h3000);
      @(posedge clk_sys);
      chip_n <= 1'h0;
      @(posedge clk_sys);
      chip_n <= 1'h1;
      rd_reg(4'h8, v); `CHK("unknown", 1'h1, v[1])
      @(posedge clk_sys);
      async_load <= 1'h1;
      @(posedge clk_sys);
      async_load <= 1'h0;
      async_clr <= 1'h1;
      #1; `CHK("aload", 1'h1, reg_out)
      @(posedge clk_sys);
      async_clr <= 1'h0;
      rd_reg(4'h8, v); `CHK("unknown", 1'h0, v[1])
      wr_reg(4'h0, 16'h0200);
      `CHK("bypass", 1'h1, reg_out)
      wr_reg(4'h0, 16'h0080);
      @(posedge clk_sys);
      clk_ena1 <= 1'h1;
      edge1(); `CHK("toggle", 1'h1, reg_out)
      edge1(); `CHK("toggle", 1'h0, reg_out)
      wr_reg(4'h4, 16'h00ff);
      wr_reg(4'h0, 16'h4400);
      eq = reg_out;
      edge1(); `CHK("feedback", ~eq, reg_out)
      edge1(); `CHK("feedback", eq, reg_out)
      $display("test register controls done");
      results();
   end
endmodule : tb
`default_nettype wire
